/* File: common/swgc_pkg.sv */
// Purpose: Constants for the two global switch control registers.
// Assumes: 25 MHz core clock; byte-wide management register port.
// Notes: Offsets are the byte addresses of the management port.
// How it works
// - Pass-all forwards every frame, errored included.
// - Pass-all acts only with sniffer mode active.
// - Control 1 bit 6 enables host-port tail tag.
// - Bit 5 clear: never emit PAUSE frames.
// - Bit 4 clear: ignore every received PAUSE.
// - Bit 3: drop length-field mismatches below 1500.
// - Control 1 bit 2 turns table aging on.
// - Control 1 bit 1 selects 800us fast aging.
// - Control 1 bit 0 selects aggressive back-off.
// - Control 2 bit 7 blocks all VLAN crossings.
// - Mirroring unavailable while VLAN discard clear.
// - Bit 6 clear: storm limit includes DA[40].
// - Bit 5 selects carrier-sense or collision backpressure.
// - Bit 4: fair drop, else throttle flow port.
// - Bit 3 clear: drop after 16 collisions.
// - Bit 2 accepts up to 1916 bytes, overriding.
// - Bit 1: 1522/1518 limit, else 1536.
package swgc_pkg;
  localparam logic [7:0] GC1_OFF = 8'h03;
  localparam logic [7:0] GC2_OFF = 8'h04;
  localparam logic [7:0] GC1_RST = 8'h38;
  localparam logic [7:0] GC2_RST = 8'hF0;
  localparam int GC1_PASS_ALL = 7;
  localparam int GC1_TAIL_TAG = 6;
  localparam int GC1_TX_FC = 5;
  localparam int GC1_RX_FC = 4;
  localparam int GC1_LEN_CHK = 3;
  localparam int GC1_AGING = 2;
  localparam int GC1_FAST_AGE = 1;
  localparam int GC1_AGGR_BO = 0;
  localparam int GC2_VLAN_DISC = 7;
  localparam int GC2_MC_STORM_OFF = 6;
  localparam int GC2_BP_CS = 5;
  localparam int GC2_FAIR = 4;
  localparam int GC2_NO_XCOL_DROP = 3;
  localparam int GC2_HUGE = 2;
  localparam int GC2_LEGAL_MAX = 1;
  localparam int DA_MC_BIT = 40;
  localparam logic [10:0] HUGE_MAX = 11'h77C;
  localparam logic [10:0] STD_MAX = 11'h600;
  localparam logic [10:0] TAG_MAX = 11'h5F2;
  localparam logic [10:0] UNTAG_MAX = 11'h5EE;
  localparam logic [15:0] LEN_TYPE_LIM = 16'h05DC;
  localparam logic [4:0] COLL_LIM = 5'h10;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAST_AGE_NS = 800000;
  localparam int NORM_AGE_S = 200;
  localparam int AGE_CNT_W = 33;
  // Fast period divides evenly by the clock period, so the count is exact.
  localparam logic [32:0] FAST_AGE_CYC = 33'(FAST_AGE_NS / CLK_PERIOD_NS);
  localparam logic [32:0] NORM_AGE_CYC = 33'((64'(NORM_AGE_S) * 64'h3B9ACA00) / 64'(CLK_PERIOD_NS));
endpackage

/* File: rtl/swgc_frm_chk.sv */
// Purpose: Per-frame size and length-field acceptance check.
// Assumes: Frame summary arrives as one strobe on the core clock.
// Notes: Verdict is registered one cycle after the strobe.
module swgc_frm_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_huge,
  input wire logic i_legal_max,
  input wire logic i_len_chk,
  input wire logic i_frm_vld,
  input wire logic [10:0] i_frm_len,
  input wire logic i_frm_tagged,
  input wire logic [15:0] i_len_type,
  input wire logic [10:0] i_payload_len,
  output logic o_drop,
  output logic o_done
);
  // Size limit: the huge setting overrides the legal-size check.
  wire logic [10:0] legal_lim = i_frm_tagged ? swgc_pkg::TAG_MAX : swgc_pkg::UNTAG_MAX;
  wire logic [10:0] std_lim = i_legal_max ? legal_lim : swgc_pkg::STD_MAX;
  wire logic [10:0] limit = i_huge ? swgc_pkg::HUGE_MAX : std_lim;
  wire logic size_bad = i_frm_len > limit;
  // Only length-coded frames are checked; type-coded ones pass.
  wire logic len_bad = i_len_chk && (i_len_type < swgc_pkg::LEN_TYPE_LIM)
    && (i_len_type != {5'h00, i_payload_len});

  // Verdict register.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_drop <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= i_frm_vld;
      o_drop <= i_frm_vld && (size_bad || len_bad);
    end
  end

  size_lim_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_frm_vld && i_huge && i_frm_len <= swgc_pkg::HUGE_MAX
      && !len_bad |=> !o_drop)
    else $error("Huge frame within limit was dropped");
  legal_lim_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_frm_vld && !i_huge && i_legal_max && !i_frm_tagged
      && i_frm_len > swgc_pkg::UNTAG_MAX |=> o_drop)
    else $error("Oversize untagged frame passed");
  len_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_frm_vld && !i_len_chk && !size_bad |=> !o_drop)
    else $error("Frame dropped with length check off");
  huge_cov_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_frm_vld && i_huge && i_frm_len > swgc_pkg::STD_MAX ##1 !o_drop);
endmodule

/* File: rtl/swgc_regs.sv */
// Purpose: Global frame, flow, VLAN, storm and size control registers.
// Assumes: Register port and event inputs are on the core clock.
// Notes: Each decision output lags its event input by one cycle.
module swgc_regs #(
  parameter logic [32:0] FAST_AGE_CYC = swgc_pkg::FAST_AGE_CYC,
  parameter logic [32:0] NORM_AGE_CYC = swgc_pkg::NORM_AGE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_sniff_on,
  input wire logic i_mirror_req,
  input wire logic i_pause_req,
  input wire logic i_pause_rx,
  input wire logic i_da_vld,
  input wire logic [47:0] i_da,
  input wire logic i_xvlan,
  input wire logic i_known_uc,
  input wire logic i_fc_conflict,
  input wire logic i_src_fc,
  input wire logic i_coll_vld,
  input wire logic [4:0] i_coll_cnt,
  input wire logic i_frm_vld,
  input wire logic [10:0] i_frm_len,
  input wire logic i_frm_tagged,
  input wire logic [15:0] i_len_type,
  input wire logic [10:0] i_payload_len,
  output logic o_pass_all,
  output logic o_tail_tag,
  output logic o_aggr_backoff,
  output logic o_cs_backpressure,
  output logic o_aging_on,
  output logic o_fast_age,
  output logic o_age_tick,
  output logic o_pause_tx,
  output logic o_pause_honor,
  output logic o_mirror_en,
  output logic o_storm_hit,
  output logic o_vlan_block,
  output logic o_fair_drop,
  output logic o_throttle,
  output logic o_coll_drop,
  output logic o_frm_drop,
  output logic o_frm_done
);
  logic [7:0] gc1_r;
  logic [7:0] gc2_r;
  logic [32:0] age_cnt_r;
  logic [32:0] age_cnt_nxt;

  // Address decode of the two registers.
  wire logic hit_gc1 = i_reg_addr == swgc_pkg::GC1_OFF;
  wire logic hit_gc2 = i_reg_addr == swgc_pkg::GC2_OFF;
  wire logic wr_gc1 = i_reg_wr && hit_gc1;
  wire logic wr_gc2 = i_reg_wr && hit_gc2;
  wire logic [7:0] rd_sel;
  assign rd_sel = hit_gc1 ? gc1_r : (hit_gc2 ? gc2_r : 8'h00);

  // Named views of the control fields.
  wire logic pass_all = gc1_r[swgc_pkg::GC1_PASS_ALL];
  wire logic tx_fc = gc1_r[swgc_pkg::GC1_TX_FC];
  wire logic rx_fc = gc1_r[swgc_pkg::GC1_RX_FC];
  wire logic aging = gc1_r[swgc_pkg::GC1_AGING];
  wire logic fast_age = gc1_r[swgc_pkg::GC1_FAST_AGE];
  wire logic vlan_disc = gc2_r[swgc_pkg::GC2_VLAN_DISC];
  wire logic mc_storm_off = gc2_r[swgc_pkg::GC2_MC_STORM_OFF];
  wire logic fair = gc2_r[swgc_pkg::GC2_FAIR];
  wire logic no_xcol_drop = gc2_r[swgc_pkg::GC2_NO_XCOL_DROP];

  // Broadcast storm scope; multicast joins only when enabled.
  wire logic da_bcast = &i_da;
  wire logic storm_nxt = i_da_vld && (da_bcast || (!mc_storm_off && i_da[swgc_pkg::DA_MC_BIT]));

  // Port-VLAN boundary: known unicast may cross only when discard is off.
  wire logic vlan_block_nxt = i_xvlan && (vlan_disc || !i_known_uc);

  // Mirroring relies on VLAN discard being set.
  wire logic mirror_nxt = i_mirror_req && vlan_disc;

  // Debug pass-all is gated by sniffer mode so it cannot leak errored frames.
  wire logic pass_all_nxt = pass_all && i_sniff_on;

  // Flow control in each direction.
  wire logic pause_tx_nxt = i_pause_req && tx_fc;
  wire logic pause_honor_nxt = i_pause_rx && rx_fc;

  // Fair mode drops from the non-flow port; otherwise the flow port waits.
  wire logic fair_drop_nxt = i_fc_conflict && fair && !i_src_fc;
  wire logic throttle_nxt = i_fc_conflict && !fair && i_src_fc;

  // Excessive collisions drop the frame unless retry-forever is chosen.
  wire logic coll_drop_nxt = i_coll_vld && !no_xcol_drop && (i_coll_cnt >= swgc_pkg::COLL_LIM);

  // Aging period select; the counter clears and holds at zero while aging is off.
  wire logic [32:0] age_period = fast_age ? FAST_AGE_CYC : NORM_AGE_CYC;
  wire logic age_wrap = age_cnt_r >= (age_period - 33'h000000001);
  assign age_cnt_nxt = (!aging || age_wrap) ? 33'h000000000 : age_cnt_r + 33'h000000001;

  // Register storage; the reserved bit is kept as written.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gc1_r <= swgc_pkg::GC1_RST;
      gc2_r <= swgc_pkg::GC2_RST;
    end else if (i_ce) begin
      if (wr_gc1) begin
        gc1_r <= i_reg_wdata;
      end
      if (wr_gc2) begin
        gc2_r <= i_reg_wdata;
      end
    end
  end

  // Read data; a read in the cycle of a write returns the old value.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce && i_reg_rd) begin
      o_reg_rdata <= rd_sel;
    end
  end

  // Static control outputs follow the stored fields.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tail_tag <= 1'b0;
      o_aggr_backoff <= 1'b0;
      o_cs_backpressure <= 1'b1;
      o_aging_on <= 1'b0;
      o_fast_age <= 1'b0;
    end else if (i_ce) begin
      o_tail_tag <= gc1_r[swgc_pkg::GC1_TAIL_TAG];
      o_aggr_backoff <= gc1_r[swgc_pkg::GC1_AGGR_BO];
      o_cs_backpressure <= gc2_r[swgc_pkg::GC2_BP_CS];
      o_aging_on <= aging;
      o_fast_age <= fast_age;
    end
  end

  // Aging counter and its tick.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      age_cnt_r <= 33'h000000000;
      o_age_tick <= 1'b0;
    end else if (i_ce) begin
      age_cnt_r <= age_cnt_nxt;
      o_age_tick <= aging && age_wrap;
    end
  end

  // Per-event decisions, one cycle after the event.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pass_all <= 1'b0;
      o_pause_tx <= 1'b0;
      o_pause_honor <= 1'b0;
      o_mirror_en <= 1'b0;
      o_storm_hit <= 1'b0;
      o_vlan_block <= 1'b0;
      o_fair_drop <= 1'b0;
      o_throttle <= 1'b0;
      o_coll_drop <= 1'b0;
    end else if (i_ce) begin
      o_pass_all <= pass_all_nxt;
      o_pause_tx <= pause_tx_nxt;
      o_pause_honor <= pause_honor_nxt;
      o_mirror_en <= mirror_nxt;
      o_storm_hit <= storm_nxt;
      o_vlan_block <= vlan_block_nxt;
      o_fair_drop <= fair_drop_nxt;
      o_throttle <= throttle_nxt;
      o_coll_drop <= coll_drop_nxt;
    end
  end

  // Frame size and length-field verdict.
  swgc_frm_chk u_frm_chk (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_huge(gc2_r[swgc_pkg::GC2_HUGE]),
    .i_legal_max(gc2_r[swgc_pkg::GC2_LEGAL_MAX]),
    .i_len_chk(gc1_r[swgc_pkg::GC1_LEN_CHK]),
    .i_frm_vld(i_frm_vld),
    .i_frm_len(i_frm_len),
    .i_frm_tagged(i_frm_tagged),
    .i_len_type(i_len_type),
    .i_payload_len(i_payload_len),
    .o_drop(o_frm_drop),
    .o_done(o_frm_done)
  );

  // Checks tie outputs to the register write or event behind them; o_aging_on, o_fast_age and o_frm_done have none.
  reset_dflt_a: assert property (@(posedge i_clk)
    $past(!i_rst_n) |-> gc1_r == swgc_pkg::GC1_RST && gc2_r == swgc_pkg::GC2_RST)
    else $error("Registers not at defaults after reset");
  read_back_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_gc2 ##1 i_ce && i_reg_rd && hit_gc2 && !i_reg_wr |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("Read did not return written value");
  pass_all_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && pass_all && i_sniff_on |=> o_pass_all)
    else $error("Pass-all not active with sniffer on");
  pass_sniff_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_sniff_on |=> !o_pass_all)
    else $error("Pass-all active without sniffer");
  tail_tag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_gc1 ##1 i_ce && !wr_gc1 |=> o_tail_tag == $past(i_reg_wdata[6], 2))
    else $error("Tail tag does not follow write");
  pause_tx_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !tx_fc |=> !o_pause_tx)
    else $error("PAUSE sent with transmit flow control off");
  pause_rx_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_pause_rx |=> o_pause_honor == $past(rx_fc))
    else $error("Received PAUSE handling wrong");
  aging_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !aging |=> !o_age_tick && age_cnt_r == 33'h000000000)
    else $error("Aging tick while aging off");
  fast_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && aging && fast_age |=> age_cnt_r < FAST_AGE_CYC)
    else $error("Fast aging counter beyond period");
  backoff_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_gc1 ##1 i_ce && !wr_gc1 |=> o_aggr_backoff == $past(i_reg_wdata[0], 2))
    else $error("Back-off select does not follow write");
  vlan_cross_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_xvlan && i_known_uc |=> o_vlan_block == $past(vlan_disc))
    else $error("Known unicast VLAN crossing wrong");
  mirror_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !vlan_disc |=> !o_mirror_en)
    else $error("Mirroring with VLAN discard clear");
  storm_mc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_da_vld && !da_bcast && i_da[swgc_pkg::DA_MC_BIT] |=> o_storm_hit == !$past(mc_storm_off))
    else $error("Multicast storm scope wrong");
  bp_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_gc2 ##1 i_ce && !wr_gc2 |=> o_cs_backpressure == $past(i_reg_wdata[5], 2))
    else $error("Backpressure mode does not follow write");
  fair_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_fc_conflict && i_src_fc && !fair |=> o_throttle && !o_fair_drop)
    else $error("Flow port not throttled in unfair mode");
  coll_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_coll_vld && i_coll_cnt == swgc_pkg::COLL_LIM |=> o_coll_drop == !$past(no_xcol_drop))
    else $error("Sixteen-collision drop wrong");

  pass_all_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_ce && wr_gc1 ##2 o_pass_all);
  age_tick_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_fast_age && o_age_tick);
  coll_retry_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_coll_vld && i_coll_cnt == swgc_pkg::COLL_LIM && no_xcol_drop);
  storm_mc_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_ce && storm_nxt && !da_bcast);
endmodule

/* File: testbench/swgc_regs_test.sv */
// Purpose: Self-checking bench for the global frame, flow, VLAN and size controls.
// Assumes: Synchronous active-low reset; the bench drives inputs at the falling edge.
// Notes: A cycle model predicts every output; the aging tick is checked by its spacing.
module swgc_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAST_P = 8;
  localparam int NORM_P = 16;
  logic i_clk, i_rst_n, i_ce, i_reg_wr, i_reg_rd, i_sniff_on, i_mirror_req, i_pause_req;
  logic i_pause_rx, i_da_vld, i_xvlan, i_known_uc, i_fc_conflict, i_src_fc, i_coll_vld;
  logic i_frm_vld, i_frm_tagged, o_age_tick;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, m1, m2, e_rd;
  logic [47:0] i_da;
  logic [4:0] i_coll_cnt;
  logic [10:0] i_frm_len, i_payload_len;
  logic [15:0] i_len_type, e_out;
  // Each bit is driven by its own output port, so this is a net.
  wire logic [15:0] seen;
  logic [31:0] r1, r2, r3;
  logic [17:0] ops[$];
  logic [10:0] lens[8] = '{11'h5EE, 11'h5EF, 11'h5F2, 11'h5F3, 11'h600, 11'h601, 11'h77C, 11'h77D};
  int ticks[$];
  int cyc = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  bit rand_reg = 0;
  bit ce_rand = 0;

  swgc_regs #(.FAST_AGE_CYC(33'h8), .NORM_AGE_CYC(33'h10)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_sniff_on(i_sniff_on),
    .i_mirror_req(i_mirror_req), .i_pause_req(i_pause_req), .i_pause_rx(i_pause_rx), .i_da_vld(i_da_vld),
    .i_da(i_da), .i_xvlan(i_xvlan), .i_known_uc(i_known_uc), .i_fc_conflict(i_fc_conflict),
    .i_src_fc(i_src_fc), .i_coll_vld(i_coll_vld), .i_coll_cnt(i_coll_cnt), .i_frm_vld(i_frm_vld),
    .i_frm_len(i_frm_len), .i_frm_tagged(i_frm_tagged), .i_len_type(i_len_type),
    .i_payload_len(i_payload_len), .o_pass_all(seen[15]), .o_tail_tag(seen[14]),
    .o_aggr_backoff(seen[13]), .o_cs_backpressure(seen[12]), .o_aging_on(seen[11]),
    .o_fast_age(seen[10]), .o_age_tick(o_age_tick), .o_pause_tx(seen[9]), .o_pause_honor(seen[8]),
    .o_mirror_en(seen[7]), .o_storm_hit(seen[6]), .o_vlan_block(seen[5]), .o_fair_drop(seen[4]),
    .o_throttle(seen[3]), .o_coll_drop(seen[2]), .o_frm_drop(seen[1]), .o_frm_done(seen[0])
  );

  // Galois shift register; one fixed seed keeps every run repeatable.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ticks must arrive exactly one period apart while the aging mode stands still.
  task automatic tick_gap(input int p);
    chk("tick count", 8'h01, 8'(ticks.size() >= 2));
    for (int k = 1; k < ticks.size(); k++) begin
      chk("tick gap", 8'(p), 8'(ticks[k] - ticks[k - 1]));
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Cycle model: outputs follow the inputs and registers seen at the previous enabled edge.
  always @(posedge i_clk) begin
    int lim;
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      end_sim();
    end else if (!i_rst_n) begin
      m1 = 8'h38;
      m2 = 8'hF0;
      e_rd = 8'h00;
      e_out = 16'h1000;
    end else if (i_ce) begin
      lim = m2[2] ? 1916 : (m2[1] ? (i_frm_tagged ? 1522 : 1518) : 1536);
      e_out[15] = m1[7] & i_sniff_on;
      e_out[14:10] = {m1[6], m1[0], m2[5], m1[2], m1[1]};
      e_out[9] = i_pause_req & m1[5];
      e_out[8] = i_pause_rx & m1[4];
      e_out[7] = i_mirror_req & m2[7];
      e_out[6] = i_da_vld & ((&i_da) | (!m2[6] & i_da[40]));
      e_out[5] = i_xvlan & (m2[7] | !i_known_uc);
      e_out[4] = i_fc_conflict & m2[4] & !i_src_fc;
      e_out[3] = i_fc_conflict & !m2[4] & i_src_fc;
      e_out[2] = i_coll_vld & !m2[3] & (i_coll_cnt >= 16);
      e_out[1] = i_frm_vld & ((i_frm_len > lim) | (m1[3] & (i_len_type < 1500) &
                 (i_len_type != {5'h00, i_payload_len})));
      e_out[0] = i_frm_vld;
      if (i_reg_rd) begin
        e_rd = (i_reg_addr == 8'h03) ? m1 : ((i_reg_addr == 8'h04) ? m2 : 8'h00);
      end
      if (i_reg_wr && i_reg_addr == 8'h03) m1 = i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 8'h04) m2 = i_reg_wdata;
    end
  end

  // Compare settled outputs, then drive the next cycle's inputs.
  always @(negedge i_clk) begin
    if (cyc > 0) begin
      chk("read data", e_rd, o_reg_rdata);
      chk("controls hi", e_out[15:8], seen[15:8]);
      chk("decisions lo", e_out[7:0], seen[7:0]);
      if (o_age_tick === 1'b1) ticks.push_back(cyc);
    end
    r1 = lfsr(r1);
    r2 = lfsr(lfsr(r1 ^ 32'h5A5A0F0F));
    r3 = lfsr(r2 ^ 32'h3C3C9696);
    i_ce = ce_rand ? (r1[3:0] != 4'h0) : 1'b1;
    {i_sniff_on, i_mirror_req, i_pause_req, i_pause_rx, i_da_vld, i_xvlan, i_known_uc} = r1[10:4];
    {i_fc_conflict, i_src_fc, i_coll_vld, i_frm_vld, i_frm_tagged} = r1[15:11];
    i_coll_cnt = r1[20:16];
    i_da = (r2[1:0] == 2'h0) ? 48'hFFFFFFFFFFFF : {r2[31:16], r3};
    i_frm_len = r2[5] ? lens[r2[4:2]] : r3[10:0];
    i_payload_len = r3[21:11];
    i_len_type = r2[6] ? {5'h00, r3[21:11]} : {5'h00, r2[17:7]};
    // Each strobe is assigned once per cycle so no glitch reaches the register port.
    if (ops.size() > 0) begin
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = ops.pop_front();
    end else if (rand_reg) begin
      i_reg_wr = r3[23] & r3[24];
      i_reg_rd = r3[25];
      i_reg_addr = (r3[27:26] == 2'h3) ? r2[25:18] : {6'h00, 1'b1, r3[26]} + 8'h01;
      i_reg_wdata = r1[31:24] & ((i_reg_addr == 8'h04) ? 8'hFE : 8'hFF);
    end else begin
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = 18'h00000;
    end
  end

  // Main sequence: reset values, random traffic, a mid-run reset, then aging periods.
  initial begin
    r1 = 32'h8743f715;
    i_rst_n = 1'b0;
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    ops.push_back({2'b01, 8'h03, 8'h00});
    ops.push_back({2'b01, 8'h04, 8'h00});
    ops.push_back({2'b10, 8'h05, 8'hA5});
    ops.push_back({2'b01, 8'h05, 8'h00});
    repeat (10) @(posedge i_clk);
    rand_reg = 1'b1;
    ce_rand = 1'b1;
    repeat (2500) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (1500) @(posedge i_clk);
    rand_reg = 1'b0;
    ce_rand = 1'b0;
    ops.push_back({2'b10, 8'h03, 8'h06});
    repeat (6) @(posedge i_clk);
    ticks.delete();
    repeat (50) @(posedge i_clk);
    tick_gap(FAST_P);
    ops.push_back({2'b10, 8'h03, 8'h04});
    repeat (6) @(posedge i_clk);
    ticks.delete();
    repeat (70) @(posedge i_clk);
    tick_gap(NORM_P);
    ops.push_back({2'b10, 8'h03, 8'h00});
    repeat (6) @(posedge i_clk);
    ticks.delete();
    repeat (40) @(posedge i_clk);
    chk("ticks while off", 8'h00, 8'(ticks.size()));
    end_sim();
  end
endmodule
